// ### sarcv_consts.svh
`ifndef SARCV_CONSTS_SVH
`define SARCV_CONSTS_SVH

// Clock period in ns (20 MHz)
`define SARCV_CLK_NS 50
// Conversion time in ns, and its count of cycles (longest time, rounded down)
`define SARCV_CONV_NS 2200
`define SARCV_CONV_CYC ((`SARCV_CONV_NS) / (`SARCV_CLK_NS))
// Old result stays valid this long in ns; count of cycles, rounded down
`define SARCV_PREV_NS 2200
`define SARCV_PREV_CYC ((`SARCV_PREV_NS) / (`SARCV_CLK_NS))
// Result width and byte width
`define SARCV_RES_W 16
`define SARCV_BYTE_W 8
// Reset values
`define SARCV_RESULT_RST 16'h0000
// Output code points
`define SARCV_CODE_POS_FS 16'h7FFF
`define SARCV_CODE_MID 16'h0000
`define SARCV_CODE_MINUS1 16'hFFFF
`define SARCV_CODE_NEG_FS 16'h8000
// Sample FIFO depth
`define SARCV_FIFO_DEPTH 4

`endif

// ### sarcv_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sarcv_consts.svh"

// Behaviour
// - Select low, busy high, FIFO not empty, convert line falling starts a conversion.
// - Select low, convert line rising drives the result bus.
// - Busy low from conversion start until new result is registered.
// - Result is 16-bit two's complement, MSB on top bus line.
// - Codes: +FS 7FFF, mid 0000, minus one step FFFF, -FS 8000.
// - Sampler tracks again as soon as a conversion finishes.
// - Select and convert both low, with a sample in the FIFO, puts sampler to hold, starts conversion.
// - Convert line falling during busy aborts and resets the converter.
// - Select and convert lines combine as a level-sensitive OR.
// - Select tied low: bus enabled whenever convert line is high.
// - Select high: no conversion start (convert line falling while busy still aborts), result bus high impedance.
// - Conversion start puts or keeps the bus in high impedance.
// - After completion, select low and convert line high show latest result.
// - Bus enabled during conversion shows the previous result.
// - Previous result stays valid 2.2 us after conversion start.
// - Bus driven only with convert line high and select low.
// - Result readable as one word or two bytes.
// - Byte select low gives upper byte, high gives lower byte.
module sarcv_core #(
    parameter int CONV_CYCLES = `SARCV_CONV_CYC,
    parameter int PREV_CYCLES = `SARCV_PREV_CYC,
    parameter int FIFO_DEPTH  = `SARCV_FIFO_DEPTH
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     select_n,
    input  wire logic                     read_not_convert,
    input  wire logic                     byte_sel,
    input  wire logic                     sample_valid,
    output logic                          sample_ready,
    input  wire logic [`SARCV_RES_W-1:0]  sample_code,
    output logic                          busy_n,
    output logic                          track,
    output logic                          prev_valid,
    output logic      [`SARCV_RES_W-1:0]  result_bus_o,
    output logic      [`SARCV_RES_W-1:0]  result_bus_oe
);
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int AGW = $clog2(PREV_CYCLES + 1);

    // Pin synchronisers: first stage read only by second stage
    sarcv_pkg::sarcv_ctrl_s sync1;
    sarcv_pkg::sarcv_ctrl_s sync2;
    sarcv_pkg::sarcv_ctrl_s prev;

    sarcv_pkg::sarcv_state_e state;
    sarcv_pkg::sarcv_state_e next_state;

    logic [CW-1:0]           conv_cnt;
    logic [CW-1:0]           next_conv_cnt;
    logic [AGW-1:0]          age_cnt;
    sarcv_pkg::sarcv_word_t  result;
    sarcv_pkg::sarcv_word_t  held;
    logic                    held_ok;

    // FIFO output side, and FIFO input ready
    logic                    fifo_valid;
    logic                    fifo_ready;
    sarcv_pkg::sarcv_word_t  fifo_data;
    logic                    sample_ready_w;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1 <= '{select_n: 1'b1, read_not_convert: 1'b1, byte_sel: 1'b0};
            sync2 <= '{select_n: 1'b1, read_not_convert: 1'b1, byte_sel: 1'b0};
            prev  <= '{select_n: 1'b1, read_not_convert: 1'b1, byte_sel: 1'b0};
        end else begin
            sync1 <= '{select_n: select_n, read_not_convert: read_not_convert,
                       byte_sel: byte_sel};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    wire cmd_low      = !sync2.select_n && !sync2.read_not_convert;
    wire cmd_low_prev = !prev.select_n && !prev.read_not_convert;
    wire cmd_fall     = cmd_low && !cmd_low_prev;
    // convert line falling while busy, select ignored
    wire rc_fall      = !sync2.read_not_convert && prev.read_not_convert;
    wire is_busy      = (state == sarcv_pkg::SARCV_CONV);
    wire abort        = is_busy && rc_fall;
    wire start        = !is_busy && cmd_fall && fifo_valid;
    wire conv_end     = is_busy && !abort && (conv_cnt == CW'(CONV_CYCLES - 1));

    // bus enable only when select low and convert line high
    wire bus_en       = !sync2.select_n && sync2.read_not_convert;
    wire [`SARCV_BYTE_W-1:0] lane_hi = result[`SARCV_RES_W-1:`SARCV_BYTE_W];
    wire [`SARCV_BYTE_W-1:0] lane_lo = result[`SARCV_BYTE_W-1:0];
    wire [`SARCV_BYTE_W-1:0] lane_sel = sync2.byte_sel ? lane_lo : lane_hi;

    always_comb begin
        next_state    = state;
        next_conv_cnt = conv_cnt;
        case (state)
            sarcv_pkg::SARCV_TRACK: begin
                if (start) begin
                    next_state    = sarcv_pkg::SARCV_CONV;
                    next_conv_cnt = '0;
                end
            end
            sarcv_pkg::SARCV_CONV: begin
                if (abort) begin
                    next_state    = sarcv_pkg::SARCV_TRACK;
                    next_conv_cnt = '0;
                end else if (conv_end) begin
                    next_state = sarcv_pkg::SARCV_DONE;
                end else begin
                    next_conv_cnt = conv_cnt + 1'b1;
                end
            end
            sarcv_pkg::SARCV_DONE: begin
                // back to tracking, new command not lost
                if (start) begin
                    next_state    = sarcv_pkg::SARCV_CONV;
                    next_conv_cnt = '0;
                end else begin
                    next_state = sarcv_pkg::SARCV_TRACK;
                end
            end
            default: begin
                next_state = sarcv_pkg::SARCV_TRACK;
            end
        endcase
    end

    // One sample taken from the FIFO per conversion start
    assign fifo_ready = start;

    always_ff @(posedge clk) begin
        if (srst) begin
            state    <= sarcv_pkg::SARCV_TRACK;
            conv_cnt <= '0;
        end else begin
            state    <= next_state;
            conv_cnt <= next_conv_cnt;
        end
    end

    // Sample held at start; register updated at end of conversion
    always_ff @(posedge clk) begin
        if (srst) begin
            held    <= `SARCV_RESULT_RST;
            held_ok <= 1'b0;
            result  <= `SARCV_RESULT_RST;
        end else begin
            if (start) begin
                held    <= fifo_data;
                held_ok <= 1'b1;
            end else if (abort) begin
                held_ok <= 1'b0;
            end
            // code points kept as given by the sampler
            if (conv_end && held_ok) begin
                result <= held;
            end
        end
    end

    // age counter for validity of the old result
    always_ff @(posedge clk) begin
        if (srst) begin
            age_cnt    <= '0;
            prev_valid <= 1'b1;
        end else if (start) begin
            age_cnt    <= '0;
            prev_valid <= 1'b1;
        end else if (is_busy) begin
            if (age_cnt == AGW'(PREV_CYCLES - 1)) begin
                prev_valid <= 1'b0;
            end else begin
                age_cnt <= age_cnt + 1'b1;
            end
        end else begin
            prev_valid <= 1'b1;
        end
    end

    // busy low through conversion, high once result stored
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_n <= 1'b1;
            track  <= 1'b1;
        end else begin
            busy_n <= (next_state != sarcv_pkg::SARCV_CONV);
            track  <= (next_state != sarcv_pkg::SARCV_CONV);
        end
    end

    // drive on enable; select tied low follows convert line
    // select high keeps bus off; start keeps bus off
    // latest result; previous result during conversion
    always_ff @(posedge clk) begin
        if (srst) begin
            result_bus_o  <= '0;
            result_bus_oe <= '0;
        end else if (bus_en) begin
            result_bus_o  <= {result[`SARCV_RES_W-1:`SARCV_BYTE_W], lane_sel};
            result_bus_oe <= '1;
        end else begin
            result_bus_o  <= '0;
            result_bus_oe <= '0;
        end
    end

    // Sampler front end: host or model pushes codes here
    sarcv_fifo #(
        .WIDTH (`SARCV_RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready_w),
        .in_data   (sample_code),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            sample_ready <= 1'b0;
        end else begin
            sample_ready <= sample_ready_w;
        end
    end

endmodule : sarcv_core

`default_nettype wire

// ### sarcv_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module sarcv_core_checker #(
    parameter int CONV_CYCLES = 44
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        select_n,
    input wire logic        read_not_convert,
    input wire logic        byte_sel,
    input wire logic        busy_n,
    input wire logic        track,
    input wire logic        prev_valid,
    input wire logic [15:0] result_bus_o,
    input wire logic [15:0] result_bus_oe
);
    localparam int BUSY_MAX = CONV_CYCLES + 1;
    logic rd_mode;
    logic cmd_low;
    assign rd_mode = !select_n && read_not_convert;
    assign cmd_low = !select_n && !read_not_convert;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    busy_start_a:
        assert property ($fell(busy_n) |-> $past(cmd_low, 3) || $past(cmd_low, 4)
                         || $past(cmd_low, 5)) else $error("busy fell with no command");
    busy_len_a:
        assert property ($fell(busy_n) |-> ##[1:BUSY_MAX] busy_n) else $error("busy too long");
    track_busy_a:
        assert property (track == busy_n) else $error("track differs from busy");
    bus_drive_a:
        assert property (result_bus_oe != 16'h0000 |-> $past(rd_mode, 3) || $past(rd_mode, 4))
            else $error("bus driven outside read");
    bus_on_a:
        assert property (rd_mode [*5] |-> result_bus_oe == 16'hFFFF) else $error("bus not on");
    bus_idle_a:
        assert property (select_n [*5] |-> result_bus_oe == 16'h0000) else $error("bus not off");
    byte_lane_a:
        assert property (result_bus_oe != 16'h0000 && !$past(byte_sel, 3) && !$past(byte_sel, 4)
                         |-> result_bus_o[7:0] == result_bus_o[15:8]) else $error("lane wrong");
    prev_keep_a:
        assert property ($fell(busy_n) |-> prev_valid [*3]) else $error("old data lost early");
    prev_back_a:
        assert property (busy_n [*2] |-> prev_valid) else $error("data flag stuck low");

    cover property ($fell(busy_n));
    cover property (!busy_n && result_bus_oe == 16'hFFFF);
    cover property ($fell(busy_n) ##[1:8] busy_n);
endmodule : sarcv_core_checker

bind sarcv_core sarcv_core_checker #(.CONV_CYCLES(CONV_CYCLES)) sarcv_core_checker_i (
    .clk(clk), .srst(srst), .select_n(select_n), .read_not_convert(read_not_convert),
    .byte_sel(byte_sel), .busy_n(busy_n), .track(track), .prev_valid(prev_valid),
    .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe));

`default_nettype wire

// ### sarcv_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sarcv_core_tb_top;
    localparam int CONV = 12;
    logic        clk;
    logic        srst;
    logic        select_n;
    logic        read_not_convert;
    logic        byte_sel;
    logic        offer;
    logic [15:0] code;
    logic        sample_valid;
    logic        sample_ready;
    logic [15:0] sample_code;
    logic        busy_n;
    logic [15:0] result_bus_o;
    logic [15:0] result_bus_oe;
    logic [15:0] prev_oe;
    logic [15:0] last;
    logic [31:0] seed;
    logic [15:0] q[$];
    logic [15:0] exp_q[$];
    logic [15:0] tbl[4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
    int          fail_count;
    int          n_checks;

    sarcv_core #(.CONV_CYCLES(CONV), .PREV_CYCLES(6), .FIFO_DEPTH(4)) sarcv_core_i (
        .clk(clk), .srst(srst), .select_n(select_n), .read_not_convert(read_not_convert),
        .byte_sel(byte_sel), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_code(sample_code), .busy_n(busy_n), .track(), .prev_valid(),
        .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe));
    sarcv_sampler_model sarcv_sampler_model_i (
        .clk(clk), .srst(srst), .offer(offer), .code_in(code), .sample_ready(sample_ready),
        .sample_valid(sample_valid), .sample_code(sample_code));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop();
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : xs

    function automatic logic [15:0] ex(input logic b);
        return b ? last : {last[15:8], last[15:8]};
    endfunction : ex

    function automatic logic sg(input int w);
        return w == 0 ? busy_n : (w == 1 ? result_bus_oe[0] : sample_valid);
    endfunction : sg

    task automatic wt(input int w, input logic v, input int lim);
        for (int k = 0; k < lim && sg(w) !== v; k++) @(posedge clk);
        if (sg(w) !== v) begin
            chk("wait", 16'(v), 16'(~v));
            report_and_stop();
        end
    endtask : wt

    // Monitor: each bus enable shows the oldest expected word
    always @(posedge clk) begin
        prev_oe <= result_bus_oe;
        if (result_bus_oe === 16'hFFFF && prev_oe !== 16'hFFFF)
            chk("result_bus", exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX, result_bus_o);
    end

    task automatic feed(input logic [15:0] c, input logic w);
        code <= c;
        offer <= 1'b1;
        q.push_back(c);
        @(posedge clk);
        offer <= 1'b0;
        @(posedge clk);
        if (w) wt(2, 1'b0, 10);
        repeat (2) @(posedge clk);
    endtask : feed

    task automatic rd(input logic b);
        byte_sel <= b;
        repeat (5) @(posedge clk);
        exp_q.push_back(ex(b));
        select_n <= 1'b0;
        @(posedge clk);
        wt(1, 1'b1, 10);
        repeat (2) @(posedge clk);
        select_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : rd

    // Modes: 0 plain, 1 read during conversion, 2 abort, 3 empty buffer
    task automatic conv(input logic cs, input int m);
        int          n;
        logic        lo;
        logic [15:0] c;
        c = last;
        if (m != 3) c = q.pop_front();
        if (cs) begin
            read_not_convert <= 1'b0;
            @(posedge clk);
            select_n <= 1'b0;
        end else begin
            exp_q.push_back(ex(byte_sel));
            select_n <= 1'b0;
            @(posedge clk);
            wt(1, 1'b1, 10);
            read_not_convert <= 1'b0;
        end
        repeat (3) @(posedge clk);
        if (m == 1) exp_q.push_back(ex(byte_sel));
        read_not_convert <= 1'b1;
        if (m != 1) select_n <= 1'b1;
        lo = 1'b0;
        repeat (m == 3 ? 12 : 1) begin
            @(posedge clk);
            lo = lo | ~busy_n;
        end
        if (m == 3) begin
            chk("busy_n", 16'h0000, 16'(lo));
            return;
        end
        wt(0, 1'b0, 10);
        n = 0;
        while (busy_n === 1'b0 && n < 200) begin
            if (m == 2 && n == 0) read_not_convert <= 1'b0;
            if (m == 2 && n == 3) read_not_convert <= 1'b1;
            n++;
            @(posedge clk);
        end
        read_not_convert <= 1'b1;
        select_n <= 1'b1;
        if (m == 2) chk("aborted", 16'h0001, 16'(n < CONV));
        else chk("busy_len", 16'(CONV), 16'(n));
        if (m != 2) last = c;
        repeat (80) @(posedge clk);
    endtask : conv

    initial begin
        srst = 1'b1;
        select_n = 1'b1;
        read_not_convert = 1'b1;
        byte_sel = 1'b0;
        offer = 1'b0;
        code = 16'h0000;
        last = 16'h0000;
        seed = 32'h000031CB;
        fail_count = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("busy_n", 16'h0001, 16'(busy_n));
        rd(1'b0);
        rd(1'b1);
        foreach (tbl[i]) feed(tbl[i], 1'b1);
        feed(16'h1234, 1'b0);
        repeat (4) @(posedge clk);
        chk("sample_ready", 16'h0000, 16'(sample_ready));
        for (int i = 0; i < 5; i++) begin
            conv(i[0], 0);
            rd(1'b0);
            rd(1'b1);
        end
        conv(1'b1, 3);
        feed(xs(), 1'b1);
        conv(1'b1, 2);
        rd(1'b1);
        feed(xs(), 1'b1);
        conv(1'b0, 1);
        for (int i = 0; i < 4; i++) begin
            feed(xs(), 1'b1);
            conv(i[1], 0);
            rd(i[0]);
        end
        chk("pending", 16'h0000, 16'(exp_q.size()));
        report_and_stop();
    end
endmodule : sarcv_core_tb_top

`default_nettype wire

// ### sarcv_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sarcv_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    wire [AW-1:0] wr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [AW-1:0] rd_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    assign in_ready  = (count != (AW + 1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_inc;
            end
            if (pop) begin
                rd_ptr <= rd_inc;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule : sarcv_fifo

`default_nettype wire

// ### sarcv_pkg.sv
package sarcv_pkg;

    typedef enum logic [1:0] {
        SARCV_TRACK = 2'b00,
        SARCV_CONV  = 2'b01,
        SARCV_DONE  = 2'b10
    } sarcv_state_e;

    typedef struct packed {
        logic        select_n;
        logic        read_not_convert;
        logic        byte_sel;
    } sarcv_ctrl_s;

    typedef logic [15:0] sarcv_word_t;

endpackage : sarcv_pkg

// ### sarcv_sampler_model.sv
`timescale 1ns/1ps
`default_nettype none

module sarcv_sampler_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        offer,
    input  wire logic [15:0] code_in,
    input  wire logic        sample_ready,
    output logic             sample_valid,
    output logic      [15:0] sample_code
);
    // Word held until taken; line then shows inverted data, A5A5 after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            sample_valid <= 1'b0;
            sample_code  <= 16'hA5A5;
        end else if (offer) begin
            sample_valid <= 1'b1;
            sample_code  <= code_in;
        end else if (sample_valid && sample_ready) begin
            sample_valid <= 1'b0;
            sample_code  <= ~sample_code;
        end
    end
endmodule : sarcv_sampler_model

`default_nettype wire
